// file: bench/qrp_assertions.sv
// Purpose: link checks between the host end and the flash end
// Assumes: sck half period of four mclk cycles
// Notes:   sees interface signals only
module qrp_assertions (
    // clock and reset
    input wire logic       mclk_i,
    input wire logic       reset_n_i,
    // link
    input wire logic       sck,
    input wire logic       cs_n,
    input wire logic [7:0] h_io,
    input wire logic       h_oe,
    input wire logic [7:0] d_io,
    input wire logic       d_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    // sck halves never shorter than four mclk cycles
    sck_high_min_a: assert property (
        $rose(sck) |=> sck[*3]) else $error("sck high half too short");
    sck_low_min_a: assert property (
        $fell(sck) |=> !sck[*3]) else $error("sck low half too short");
    // host launches io while sck is low
    host_launch_a: assert property (
        $changed(h_io) |-> !sck) else $error("host io changed with sck high");
    // flash byte steps only after a falling edge
    byte_hold_a: assert property (
        sck && $past(sck) |-> $stable(d_io)) else $error("flash io moved in high half");
    // never both ends driving
    no_contend_a: assert property (
        !(h_oe && d_oe)) else $error("both ends drive io");
    // flash silent for eight mclk cycles after chip select falls
    frame_start_a: assert property (
        $fell(cs_n) |=> !d_oe[*8]) else $error("flash drove at frame start");
    // chip select rise ends the read
    read_end_a: assert property (
        cs_n[*5] |-> !d_oe) else $error("flash still drives after deselect");
    // host idle outside frames
    host_idle_a: assert property (
        cs_n |-> !sck && !h_oe) else $error("host active while deselected");
endmodule : qrp_assertions

// file: bench/quad_io_read_path_tb.sv
// Purpose: end to end reads through host end and flash end
// Assumes: memory byte is low address byte xor top address byte
// Notes:   sck comes from the host divider
module quad_io_read_path_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import qrp_pkg::*;
    logic        mclk_i = 0, reset_n_i = 0, req_i = 0, four = 0, wae = 0, keep = 0;
    logic [31:0] addr = 0, mem_addr;
    logic [15:0] len = 0;
    logic [7:0]  bank = 8'h00, rd_data;
    logic [1:0]  lc = 2'h0;
    logic [3:0]  dum = QRP_DUMMY_LC0;
    logic [3:0]  dtab [4] = '{QRP_DUMMY_LC0, QRP_DUMMY_LC1, QRP_DUMMY_LC2, QRP_DUMMY_LC3};
    logic        ready, rd_valid, busy, h_cont, f_cont, ract;
    int          fail_count = 0, checks = 0;
    qrp_link_if qrp_link_if_inst ();
    qrp_flash_end qrp_flash_end_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .link(qrp_link_if_inst.flash), .mem_addr_o(mem_addr),
        .mem_data_i(mem_addr[7:0] ^ mem_addr[31:24]), .wide_address_enable_i(wae),
        .bank_addr_i(bank), .read_latency_code_i(lc), .cont_mode_o(f_cont), .read_active_o(ract));
    qrp_host_end #(.SCK_HALF(4)) qrp_host_end_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .link(qrp_link_if_inst.host), .req_i(req_i), .req_ready_o(ready), .req_addr_i(addr),
        .req_len_i(len), .req_four_cmd_i(four), .wide_address_enable_i(wae),
        .dummy_cycles_i(dum), .keep_cont_i(keep), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
        .busy_o(busy), .cont_mode_o(h_cont));
    qrp_assertions qrp_assertions_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .sck(qrp_link_if_inst.sck), .cs_n(qrp_link_if_inst.cs_n), .h_io(qrp_link_if_inst.h_io),
        .h_oe(qrp_link_if_inst.h_oe), .d_io(qrp_link_if_inst.d_io), .d_oe(qrp_link_if_inst.d_oe));
    // system clock
    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    // compare and count
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // one read request, bytes compared in address order
    task automatic read(input logic [31:0] a, input logic [15:0] n, input logic f, input logic k);
        logic [31:0] ea;
        int          t;
        while (ready !== 1'b1) @(negedge mclk_i);
        req_i = 1;
        addr = a;
        len = n;
        four = f;
        keep = k;
        @(negedge mclk_i);
        req_i = 0;
        check({6'h0, busy, ready}, 8'h02);
        ea = (f || wae) ? a : {bank, a[23:0]};
        for (int i = 0; i < n; i++) begin
            t = 0;
            do begin
                @(posedge mclk_i);
                #1 t++;
            end while (rd_valid !== 1'b1 && t < 2000);
            // a byte that never came counts as a mismatch
            if (t >= 2000) begin
                fail_count++;
                $display("byte wait ran out at %0t", $time);
            end
            check(rd_data, ea[7:0] ^ ea[31:24]);
            check({7'h0, ract}, 8'h01);
            ea++;
        end
        while (ready !== 1'b1) @(negedge mclk_i);
        @(negedge mclk_i);
        check({7'h0, ract}, 8'h00);
    endtask : read
    // verdict and end of run
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    // hang guard
    initial begin
        #800000 fail_count++;
        end_of_test();
    end
    // test sequence
    initial begin
        repeat (8) @(negedge mclk_i);
        reset_n_i = 1;
        bank = 8'h12;
        read(32'h00ff_fffe, 16'd3, 1'b0, 1'b1);
        check({7'h0, f_cont}, 8'h01);
        check({7'h0, h_cont}, 8'h01);
        read(32'h0000_0100, 16'd2, 1'b0, 1'b0);
        check({7'h0, f_cont}, 8'h00);
        check({7'h0, h_cont}, 8'h00);
        for (int i = 0; i < 4; i++) begin
            lc = 2'(i);
            dum = dtab[i];
            read(32'hffff_fffe, 16'd3, 1'b1, 1'b0);
        end
        wae = 1;
        read(32'hab00_0010, 16'd2, 1'b0, 1'b0);
        end_of_test();
    end
endmodule : quad_io_read_path_tb

// file: design/qrp_flash_end.sv
// Purpose: flash side of the wide quad read: opcode, wide address, mode, dummy, data
// Assumes: sck mode 0, sck at most a quarter of mclk; memory answers mem_data_i
//          combinationally for mem_addr_o
// Notes:   all link pins pass two flops; edges found on the second stage
// Notes on behaviour
// - EBh uses flag for 3/4 bytes; ECh four
// - address arrives eight bits per sck cycle
// - host keeps sck at or below 104 MHz
// - ignore io lines during dummy cycles
// - dummy count from latency code field
// - drive one byte per sck falling edge
// - address increments per byte, wraps to zero
// - mode upper nibble decides, lower nibble ignored
// - mode Axh keeps continuous, next frame address-first
// - other mode exits continuous at chip select rise
// - short invalid frame also exits continuous mode
// - mode byte takes two cycles after address
// - host releases io by first data edge
// - host may release io during mode/dummy
// - host keeps chip select low through latency
// - four-byte flag makes EBh take four bytes
// - opcode serial, one bit per rising edge
// - chip select rise ends the read immediately
// - dummy counted falling to falling; zero allowed
module qrp_flash_end (
    // clock and reset
    input  wire logic                            mclk_i,
    input  wire logic                            reset_n_i,
    // link to host
    qrp_link_if.flash                            link,
    // memory array
    output logic [qrp_pkg::QRP_ADDR_W-1:0]       mem_addr_o,
    input  wire logic [7:0]                      mem_data_i,
    // configuration
    input  wire logic                            wide_address_enable_i,
    input  wire logic [qrp_pkg::QRP_BANK_W-1:0]  bank_addr_i,
    input  wire logic [qrp_pkg::QRP_LC_W-1:0]    read_latency_code_i,
    // status
    output logic                                 cont_mode_o,
    output logic                                 read_active_o
);
    import qrp_pkg::*;

    typedef enum logic [6:0] {
        QRP_S_IDLE  = 7'h01,
        QRP_S_CMD   = 7'h02,
        QRP_S_ADDR  = 7'h04,
        QRP_S_MODE  = 7'h08,
        QRP_S_DUMMY = 7'h10,
        QRP_S_DATA  = 7'h20,
        QRP_S_SKIP  = 7'h40
    } qrp_dev_state_type;

    // synchronisers
    logic                  sck_s1_q, sck_s2_q, sck_s3_q; // s3 only for edge find
    logic                  cs_s1_q, cs_s2_q, cs_s3_q;
    logic [7:0]            io_s1_q, io_s2_q;
    // control state
    qrp_dev_state_type     state_q, state_d;
    logic [3:0]            cnt_q, cnt_d;      // cycles within a phase
    logic [3:0]            rise_cnt_q;        // sck rises this frame, saturating
    logic [7:0]            cmd_q;             // opcode shift
    logic [QRP_ADDR_W-1:0] addr_q;            // address shift, then read pointer
    logic                  four_q;            // four address bytes
    logic                  cont_q;            // continuous read mode
    logic                  mode_seen_q;       // mode byte taken this frame
    logic                  mode_keep_q;       // taken mode byte asked to stay
    logic [7:0]            dout_q;            // byte on io
    logic                  oe_q;              // flash drives io

    // edges of the synchronised pins
    wire        cs_low     = ~cs_s2_q;
    wire        cs_rise    = cs_s2_q & ~cs_s3_q;
    wire        cs_fall    = ~cs_s2_q & cs_s3_q;
    wire        sck_rise   = sck_s2_q & ~sck_s3_q & cs_low;
    wire        sck_fall   = ~sck_s2_q & sck_s3_q & cs_low;
    // phase decode
    wire        st_cmd     = (state_q == QRP_S_CMD);
    wire        st_addr    = (state_q == QRP_S_ADDR);
    wire        st_mode    = (state_q == QRP_S_MODE);
    wire        st_dummy   = (state_q == QRP_S_DUMMY);
    wire        st_data    = (state_q == QRP_S_DATA);
    wire [3:0]  dummy_n    = qrp_dummy_cycles(read_latency_code_i);
    wire [3:0]  addr_bytes = four_q ? QRP_ADDR4 : QRP_ADDR3;
    wire        last_addr  = (cnt_q == addr_bytes - 4'h1);
    wire        last_cmd   = (cnt_q == QRP_CMD_BITS - 4'h1);
    wire        dummy_done = (cnt_q == dummy_n);
    wire [7:0]  cmd_next   = {cmd_q[6:0], io_s2_q[0]};
    wire        cmd_ok     = (cmd_next == QRP_CMD_WIDE) | (cmd_next == QRP_CMD_WIDE4);
    // ECh always four bytes, EBh follows the flag
    wire        cmd_four   = (cmd_next == QRP_CMD_WIDE4) | wide_address_enable_i;
    wire [QRP_ADDR_W-1:0] addr_shift = {addr_q[QRP_ADDR_W-9:0], io_s2_q};
    // three-byte form takes the upper bits from the bank register
    wire [QRP_ADDR_W-1:0] full_addr  =
        four_q ? addr_shift : {bank_addr_i, addr_shift[23:0]};
    // first falling edge of data and every one after
    wire        data_step  = sck_fall & ((st_dummy & dummy_done) | st_data);
    // continuous frame dropped before its mode byte, within eight cycles
    wire        short_abort = cont_q & ~mode_seen_q & (rise_cnt_q <= QRP_ABORT_MAX);

    // pin synchronisers, first stage feeds only the second
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
            cs_s1_q  <= 1'b1;
            cs_s2_q  <= 1'b1;
            cs_s3_q  <= 1'b1;
            io_s1_q  <= 8'h00;
            io_s2_q  <= 8'h00;
        end else begin
            sck_s1_q <= link.sck;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            cs_s1_q  <= link.cs_n;
            cs_s2_q  <= cs_s1_q;
            cs_s3_q  <= cs_s2_q;
            io_s1_q  <= link.io;
            io_s2_q  <= io_s1_q;
        end
    end

    // phase sequencing
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            QRP_S_IDLE: begin
                state_d = QRP_S_IDLE;                 // wait for chip select
            end
            QRP_S_CMD: begin
                if (sck_rise) begin
                    cnt_d = cnt_q + 4'h1;
                    if (last_cmd) begin
                        cnt_d   = 4'h0;
                        state_d = cmd_ok ? QRP_S_ADDR : QRP_S_SKIP;
                    end
                end
            end
            QRP_S_ADDR: begin
                if (sck_rise) begin
                    cnt_d = cnt_q + 4'h1;
                    if (last_addr) begin
                        cnt_d   = 4'h0;
                        state_d = QRP_S_MODE;
                    end
                end
            end
            QRP_S_MODE: begin
                if (sck_rise) begin
                    cnt_d = cnt_q + 4'h1;
                    if (cnt_q == QRP_MODE_CYC - 4'h1) begin
                        cnt_d   = 4'h0;
                        state_d = QRP_S_DUMMY;
                    end
                end
            end
            QRP_S_DUMMY: begin
                // io lines not looked at here
                if (sck_fall) begin
                    cnt_d = cnt_q + 4'h1;
                    if (dummy_done) begin
                        cnt_d   = 4'h0;
                        state_d = QRP_S_DATA;
                    end
                end
            end
            QRP_S_DATA: begin
                state_d = QRP_S_DATA;                 // until chip select rises
            end
            QRP_S_SKIP: begin
                state_d = QRP_S_SKIP;                 // foreign opcode, sit out frame
            end
            default: begin
                state_d = QRP_S_IDLE;
                cnt_d   = 4'h0;
            end
        endcase
        if (cs_rise) begin
            state_d = QRP_S_IDLE;
            cnt_d   = 4'h0;
        end else if (cs_fall) begin
            // continuous mode skips the opcode
            state_d = cont_q ? QRP_S_ADDR : QRP_S_CMD;
            cnt_d   = 4'h0;
        end
    end

    // state registers
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            state_q <= QRP_S_IDLE;
            cnt_q   <= 4'h0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // frame rise counter for short-frame detection
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            rise_cnt_q <= 4'h0;
        end else if (cs_fall) begin
            rise_cnt_q <= 4'h0;
        end else if (sck_rise && rise_cnt_q != 4'hf) begin
            rise_cnt_q <= rise_cnt_q + 4'h1;
        end
    end

    // opcode and address capture
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            cmd_q  <= 8'h00;
            four_q <= 1'b0;
            addr_q <= '0;
        end else begin
            if (st_cmd && sck_rise) begin
                cmd_q <= cmd_next;
            end
            if (st_cmd && sck_rise && last_cmd) begin
                four_q <= cmd_four;
            end
            if (st_addr && sck_rise) begin
                addr_q <= last_addr ? full_addr : addr_shift;
            end else if (data_step) begin
                addr_q <= addr_q + 1'b1;
            end
        end
    end

    // output byte and enable
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            dout_q <= 8'h00;
            oe_q   <= 1'b0;
        end else begin
            if (data_step) begin
                dout_q <= mem_data_i;
            end
            if (cs_rise || cs_fall) begin
                oe_q <= 1'b0;
            end else if (data_step) begin
                oe_q <= 1'b1;
            end
        end
    end

    // mode byte and continuous read state
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            mode_seen_q <= 1'b0;
            mode_keep_q <= 1'b0;
            cont_q      <= 1'b0;
        end else if (cs_rise) begin
            mode_seen_q <= 1'b0;
            if (mode_seen_q) begin
                cont_q <= mode_keep_q;
            end else if (short_abort) begin
                cont_q <= 1'b0;
            end
        end else if (cs_fall) begin
            mode_seen_q <= 1'b0;
        end else if (st_mode && sck_rise && cnt_q == 4'h0) begin
            // first mode cycle carries the byte, lower nibble unused
            mode_seen_q <= 1'b1;
            mode_keep_q <= (io_s2_q[7:4] == QRP_MODE_KEEP);
        end
    end

    // outputs
    assign mem_addr_o    = addr_q;
    assign link.d_io     = dout_q;
    assign link.d_oe     = oe_q;
    assign cont_mode_o   = cont_q;
    assign read_active_o = oe_q;
endmodule : qrp_flash_end

// file: design/qrp_host_end.sv
// Purpose: host side of the wide quad read, makes sck and chip select
// Assumes: user asks one read at a time; dummy count matches flash latency code
// Notes:   sck is mclk divided; read data sampled just before each falling edge
module qrp_host_end #(
    parameter int SCK_HALF = qrp_pkg::QRP_SCK_HALF_CYC  // mclk cycles per sck half
) (
    // clock and reset
    input  wire logic                            mclk_i,
    input  wire logic                            reset_n_i,
    // link to flash
    qrp_link_if.host                             link,
    // request
    input  wire logic                            req_i,
    output logic                                 req_ready_o,
    input  wire logic [qrp_pkg::QRP_ADDR_W-1:0]  req_addr_i,
    input  wire logic [15:0]                     req_len_i,
    input  wire logic                            req_four_cmd_i,
    input  wire logic                            wide_address_enable_i,
    input  wire logic [qrp_pkg::QRP_DUM_W-1:0]   dummy_cycles_i,
    input  wire logic                            keep_cont_i,
    // read data
    output logic [7:0]                           rd_data_o,
    output logic                                 rd_valid_o,
    // status
    output logic                                 busy_o,
    output logic                                 cont_mode_o
);
    import qrp_pkg::*;

    typedef enum logic [4:0] {
        QRP_H_IDLE = 5'h01,
        QRP_H_LEAD = 5'h02,
        QRP_H_RUN  = 5'h04,
        QRP_H_TAIL = 5'h08,
        QRP_H_GAP  = 5'h10
    } qrp_host_state_type;

    qrp_host_state_type    st_q;
    logic [7:0]            div_q;            // half period counter
    logic                  sck_q, cs_n_q;
    logic [16:0]           cyc_q;            // sck cycle index in frame
    logic [QRP_ADDR_W-1:0] addr_q;
    logic [15:0]           len_q;
    logic [7:0]            cmd_q;
    logic [3:0]            dum_q;
    logic                  four_q, skip_q, keep_q, cont_q;
    logic [7:0]            io_q, io_s1_q, io_s2_q, rd_q;
    logic                  oe_q, valid_q;

    // frame layout in sck cycles
    wire        half_done = (div_q == 8'(SCK_HALF - 1));
    wire [16:0] n_cmd     = skip_q ? 17'h0 : 17'(QRP_CMD_BITS);
    wire [16:0] n_adr     = four_q ? 17'(QRP_ADDR4) : 17'(QRP_ADDR3);
    wire [16:0] mode_ix   = n_cmd + n_adr;
    wire [16:0] data_ix   = mode_ix + 17'(QRP_MODE_CYC) + 17'(dum_q);
    wire [16:0] total     = data_ix + 17'(len_q);
    wire [16:0] ix        = (st_q == QRP_H_LEAD) ? 17'h0 : cyc_q + 17'h1;
    wire [16:0] k         = ix - n_cmd;
    wire [4:0]  sh        = 5'((n_adr - 17'h1 - k) * 17'h8);
    wire [QRP_ADDR_W-1:0] abyte = addr_q >> sh;
    // value for the next cycle; opcode on io0, msb first
    wire [7:0]  nxt_io    = (ix < n_cmd)   ? {7'h0, cmd_q[3'(17'h7 - ix)]} :
                            (ix < mode_ix) ? abyte[7:0] :
                            (keep_q ? QRP_MODE_KEEP_BYTE : QRP_MODE_EXIT_BYTE);
    // release after the first mode cycle
    wire        nxt_oe    = (ix <= mode_ix);

    // data sampler, first stage feeds only the second
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            io_s1_q <= 8'h00;
            io_s2_q <= 8'h00;
        end else begin
            io_s1_q <= link.io;
            io_s2_q <= io_s1_q;
        end
    end

    // half period divider
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i || st_q == QRP_H_IDLE || half_done) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h1;
        end
    end

    // request latch
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            addr_q <= '0;
            len_q  <= 16'h0;
            cmd_q  <= QRP_CMD_WIDE;
            dum_q  <= 4'h0;
            four_q <= 1'b0;
            skip_q <= 1'b0;
            keep_q <= 1'b0;
        end else if (st_q == QRP_H_IDLE && req_i) begin
            addr_q <= req_addr_i;
            len_q  <= req_len_i;
            cmd_q  <= req_four_cmd_i ? QRP_CMD_WIDE4 : QRP_CMD_WIDE;
            dum_q  <= dummy_cycles_i;
            skip_q <= cont_q;
            keep_q <= keep_cont_i;
            // continuous frames keep the width of the opening command
            four_q <= cont_q ? four_q : (req_four_cmd_i | wide_address_enable_i);
        end
    end

    // frame sequencer: sck, chip select, io drive, capture
    always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
            st_q    <= QRP_H_IDLE;
            sck_q   <= 1'b0;
            cs_n_q  <= 1'b1;
            cyc_q   <= 17'h0;
            io_q    <= 8'h00;
            oe_q    <= 1'b0;
            rd_q    <= 8'h00;
            valid_q <= 1'b0;
            cont_q  <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            case (st_q)
                QRP_H_IDLE: begin
                    if (req_i) begin
                        st_q   <= QRP_H_LEAD;
                        cs_n_q <= 1'b0;
                        cyc_q  <= 17'h0;
                    end
                end
                QRP_H_LEAD: begin
                    if (half_done) begin
                        st_q <= QRP_H_RUN;
                        io_q <= nxt_io;
                        oe_q <= nxt_oe;
                    end
                end
                QRP_H_RUN: begin
                    if (half_done && !sck_q) begin
                        sck_q <= 1'b1;
                    end else if (half_done) begin
                        sck_q <= 1'b0;
                        if (cyc_q >= data_ix) begin
                            rd_q    <= io_s2_q;
                            valid_q <= 1'b1;
                        end
                        if (cyc_q + 17'h1 >= total) begin
                            st_q <= QRP_H_TAIL;
                            oe_q <= 1'b0;
                        end else begin
                            cyc_q <= cyc_q + 17'h1;
                            io_q  <= nxt_io;
                            oe_q  <= nxt_oe;
                        end
                    end
                end
                QRP_H_TAIL: begin
                    if (half_done) begin
                        st_q   <= QRP_H_GAP;
                        cs_n_q <= 1'b1;
                        cont_q <= keep_q;
                    end
                end
                QRP_H_GAP: begin
                    if (half_done) begin
                        st_q <= QRP_H_IDLE;
                    end
                end
                default: begin
                    st_q <= QRP_H_IDLE;
                end
            endcase
        end
    end

    // outputs
    assign link.sck    = sck_q;
    assign link.cs_n   = cs_n_q;
    assign link.h_io   = io_q;
    assign link.h_oe   = oe_q;
    assign req_ready_o = (st_q == QRP_H_IDLE);
    assign busy_o      = (st_q != QRP_H_IDLE);
    assign rd_data_o   = rd_q;
    assign rd_valid_o  = valid_q;
    assign cont_mode_o = cont_q;
endmodule : qrp_host_end

// file: design/qrp_link_if.sv
// Purpose: link between host end and flash end (sck, chip select, 8 io lines)
// Assumes: one output enable covers all eight lines of each party
// Notes:   undriven lines read high as if pulled up; host enable wins on contention
interface qrp_link_if;
    logic       sck;   // link clock from host, idle low
    logic       cs_n;  // chip select, active low
    logic [7:0] h_io;  // host drive value
    logic       h_oe;  // host drives io
    logic [7:0] d_io;  // flash drive value
    logic       d_oe;  // flash drives io
    logic [7:0] io;    // resolved line level

    // resolve wire level from enables
    assign io = h_oe ? h_io : (d_oe ? d_io : 8'hff);

    modport flash (input sck, input cs_n, input io, output d_io, output d_oe);
    modport host  (output sck, output cs_n, output h_io, output h_oe, input io);
endinterface : qrp_link_if

// file: design/qrp_pkg.sv
// Purpose: shared constants for the wide quad read path (flash end and host end)
// Assumes: 8 io lines, one byte per sck cycle in the wide phases
// Notes:   timing counts derive from the 25 MHz system clock
package qrp_pkg;
    // opcodes and mode byte
    localparam logic [7:0] QRP_CMD_WIDE      = 8'heb; // wide_quad_read_cmd
    localparam logic [7:0] QRP_CMD_WIDE4     = 8'hec; // wide_quad_read_4byte_cmd
    localparam logic [3:0] QRP_MODE_KEEP     = 4'ha;  // upper nibble that keeps continuous
    localparam logic [7:0] QRP_MODE_KEEP_BYTE = 8'ha0; // mode byte sent to stay continuous
    localparam logic [7:0] QRP_MODE_EXIT_BYTE = 8'h00; // mode byte sent to leave
    // phase lengths in sck cycles
    localparam logic [3:0] QRP_CMD_BITS      = 4'h8;
    localparam logic [3:0] QRP_ADDR3         = 4'h3;
    localparam logic [3:0] QRP_ADDR4         = 4'h4;
    localparam logic [3:0] QRP_MODE_CYC      = 4'h2;
    localparam logic [3:0] QRP_ABORT_MAX     = 4'h8;  // short frame that drops continuous
    // widths
    localparam int QRP_ADDR_W = 32;
    localparam int QRP_BANK_W = 8;
    localparam int QRP_LC_W   = 2;
    localparam int QRP_DUM_W  = 4;
    // link timing
    localparam int QRP_MCLK_PERIOD_NS = 40;
    localparam int QRP_SCK_PERIOD_NS  = 320;
    localparam int QRP_SCK_MAX_MHZ    = 104;
    localparam int QRP_SCK_HALF_CYC   = QRP_SCK_PERIOD_NS / (2 * QRP_MCLK_PERIOD_NS);
    // least half period allowed at the sck ceiling, rounded up, at least one cycle
    localparam int QRP_SCK_MIN_HALF_CYC =
        (1000 + 2 * QRP_SCK_MAX_MHZ * QRP_MCLK_PERIOD_NS - 1)
        / (2 * QRP_SCK_MAX_MHZ * QRP_MCLK_PERIOD_NS);
    // dummy cycles per latency code, same for both tables
    localparam logic [3:0] QRP_DUMMY_LC0 = 4'h4;
    localparam logic [3:0] QRP_DUMMY_LC1 = 4'h5;
    localparam logic [3:0] QRP_DUMMY_LC2 = 4'h6;
    localparam logic [3:0] QRP_DUMMY_LC3 = 4'h0;

    // latency code to dummy count
    function automatic logic [3:0] qrp_dummy_cycles(input logic [1:0] code);
        case (code)
            2'h0:    qrp_dummy_cycles = QRP_DUMMY_LC0;
            2'h1:    qrp_dummy_cycles = QRP_DUMMY_LC1;
            2'h2:    qrp_dummy_cycles = QRP_DUMMY_LC2;
            default: qrp_dummy_cycles = QRP_DUMMY_LC3;
        endcase
    endfunction : qrp_dummy_cycles
endpackage : qrp_pkg
